// ---- design/clksel_top.sv ----
// Clock source selector with doze and aux pin control
//
// Decided for this implementation: the address map and the strobed register port.
`include "clksel_defs.svh"
`default_nettype none
module clksel_top
    import clksel_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [3:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [15:0] rdata,
    input wire logic frc_tick,
    input wire logic low_power_rc_mode_tick,
    input wire logic posc_tick,
    input wire logic pll_out_tick,
    input wire logic aux_crystal_pin_in,
    output logic pll_ref_tick,
    output logic pll_en,
    output logic posc_en,
    output logic [1:0] posc_kind,
    output logic cpu_clock,
    output logic peripheral_clock,
    output logic aux_crystal_pin_out,
    output logic aux_crystal_pin_oe
);
    clksel_cfg_t cfg_reg;
    clksel_doze_t doze_reg;
    clksel_mode_t mode_reg;
    clksel_mode_t mode_next;
    logic [15:0] rdata_reg;
    logic pll_ref_reg;
    logic pll_en_reg;
    logic posc_en_reg;
    logic [1:0] posc_kind_reg;
    logic cpu_reg;
    logic periph_reg;
    logic pin_out_reg;
    logic pin_oe_reg;
    logic pin_in_reg;
    logic divn_tick;
    logic div16_tick;
    logic doze_tick;
    logic src_tick;
    logic ref_tick;
    logic doze_on;

    // Maps the selection fields onto one operating mode
    function automatic clksel_mode_t decode_mode(input clksel_cfg_t c);
        clksel_mode_t m;
        m = fast_rc_mode;
        case (c.new_source_code)
            // (R1) fast RC divide-by-N
            `CLKSEL_SRC_FRC_DIVN: m = fast_rc_div_n_mode;
            // (R2) fast RC divide-by-16
            `CLKSEL_SRC_FRC_DIV16: m = fast_rc_div_sixteen_mode;
            // (R3) low-power RC
            `CLKSEL_SRC_LOW_POWER_RC_MODE: m = low_power_rc_mode;
            `CLKSEL_SRC_POSC_PLL: begin
                case (c.primary_osc_mode)
                    // (R4) fast crystal with PLL
                    `CLKSEL_PMODE_HS: m = high_speed_crystal_pll_mode;
                    // (R5) medium crystal with PLL
                    `CLKSEL_PMODE_XT: m = medium_crystal_pll_mode;
                    // (R6) external clock with PLL
                    `CLKSEL_PMODE_EC: m = ext_clock_pll_mode;
                    default: m = fast_rc_mode;
                endcase
            end
            `CLKSEL_SRC_POSC: begin
                // (R12) primary without PLL
                case (c.primary_osc_mode)
                    `CLKSEL_PMODE_HS: m = high_speed_crystal;
                    `CLKSEL_PMODE_XT: m = medium_crystal;
                    `CLKSEL_PMODE_EC: m = clock_input_mode;
                    default: m = fast_rc_mode;
                endcase
            end
            // (R7) fast RC divide-by-N into PLL
            `CLKSEL_SRC_FRC_PLL: m = fast_rc_pll_mode;
            // (R8) undivided fast RC
            `CLKSEL_SRC_FRC: m = fast_rc_mode;
            // Reserved code: fall back to a clock that always runs
            default: m = fast_rc_mode;
        endcase
        return m;
    endfunction

    // Crystal modes own both oscillator pins
    function automatic logic is_crystal(input clksel_mode_t m);
        return m == high_speed_crystal_pll_mode
            || m == medium_crystal_pll_mode
            || m == high_speed_crystal
            || m == medium_crystal;
    endfunction

    // Post-scaler shared by divide-by-N and the PLL reference path
    clksel_div u_divn (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .ce(ce),
        .in_tick(frc_tick),
        .div_log2({1'b0, doze_reg.frc_div_log2}),
        .out_tick(divn_tick)
    );

    // (R2) fixed divide by sixteen
    clksel_div u_div16 (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .ce(ce),
        .in_tick(frc_tick),
        .div_log2(`CLKSEL_DIV16_LOG2),
        .out_tick(div16_tick)
    );

    // Doze ratio 1:2^n applied to the CPU only
    clksel_div u_doze (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .ce(ce),
        .in_tick(src_tick),
        .div_log2({1'b0, doze_reg.doze_ratio}),
        .out_tick(doze_tick)
    );

    assign mode_next = decode_mode(cfg_reg);

    // Source and PLL reference follow the current mode
    always_comb begin
        src_tick = 1'b0;
        ref_tick = 1'b0;
        case (mode_reg)
            fast_rc_div_n_mode: src_tick = divn_tick;
            fast_rc_div_sixteen_mode: src_tick = div16_tick;
            low_power_rc_mode: src_tick = low_power_rc_mode_tick;
            high_speed_crystal_pll_mode,
            medium_crystal_pll_mode,
            ext_clock_pll_mode: begin
                src_tick = pll_out_tick;
                ref_tick = posc_tick;
            end
            high_speed_crystal,
            medium_crystal,
            clock_input_mode: src_tick = posc_tick;
            fast_rc_pll_mode: begin
                src_tick = pll_out_tick;
                ref_tick = divn_tick;
            end
            fast_rc_mode: src_tick = frc_tick;
            default: src_tick = frc_tick;
        endcase
    end

    // (R10) doze only matters at 1:2 or slower
    assign doze_on = doze_reg.doze_en && (doze_reg.doze_ratio != 3'h0);

    // (R9) erased fields select divide-by-N
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_reg <= `CLKSEL_CFG_RESET;
        end else if (ce && wr_stb && addr == `CLKSEL_ADDR_CFG) begin
            cfg_reg.new_source_code <= wdata[`CLKSEL_SRC_LSB +: 3];
            cfg_reg.primary_osc_mode <= wdata[`CLKSEL_PMODE_LSB +: 2];
            cfg_reg.clockout_pin_cfg <= wdata[`CLKSEL_PINCFG_BIT];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            doze_reg <= `CLKSEL_DOZE_RESET;
        end else if (ce && wr_stb && addr == `CLKSEL_ADDR_DOZE) begin
            doze_reg.doze_en <= wdata[`CLKSEL_DOZE_EN_BIT];
            doze_reg.doze_ratio <= wdata[`CLKSEL_DOZE_RATIO_LSB +: 3];
            doze_reg.frc_div_log2 <= wdata[`CLKSEL_DIVN_LSB +: 3];
        end
    end

    // (R9) reset mode matches the erased decode
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_reg <= fast_rc_div_n_mode;
        end else if (ce) begin
            mode_reg <= mode_next;
        end
    end

    // Oscillator and PLL enables
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pll_en_reg <= 1'b0;
            posc_en_reg <= 1'b0;
            posc_kind_reg <= `CLKSEL_PMODE_EC;
            pll_ref_reg <= 1'b0;
        end else if (ce) begin
            // (R4) PLL modes enable the PLL
            pll_en_reg <= mode_reg == high_speed_crystal_pll_mode
                || mode_reg == medium_crystal_pll_mode
                || mode_reg == ext_clock_pll_mode
                || mode_reg == fast_rc_pll_mode;
            // (R12) primary oscillator in use
            posc_en_reg <= mode_reg == high_speed_crystal_pll_mode
                || mode_reg == medium_crystal_pll_mode
                || mode_reg == ext_clock_pll_mode
                || mode_reg == high_speed_crystal
                || mode_reg == medium_crystal
                || mode_reg == clock_input_mode;
            posc_kind_reg <= cfg_reg.primary_osc_mode;
            // (R7) reference into the PLL
            pll_ref_reg <= ref_tick;
        end
    end

    // (R10) peripherals keep the full rate
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            periph_reg <= 1'b0;
            cpu_reg <= 1'b0;
        end else if (ce) begin
            periph_reg <= src_tick;
            cpu_reg <= doze_on ? doze_tick : src_tick;
        end
    end

    // (R11) aux pin: crystal, clock out or released
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_oe_reg <= 1'b0;
            pin_out_reg <= 1'b0;
            pin_in_reg <= 1'b0;
        end else if (ce) begin
            pin_in_reg <= aux_crystal_pin_in;
            if (is_crystal(mode_reg) || cfg_reg.clockout_pin_cfg) begin
                pin_oe_reg <= 1'b0;
                pin_out_reg <= 1'b0;
            end else begin
                pin_oe_reg <= 1'b1;
                // Toggle keeps the pin at half the CPU tick rate
                if (cpu_reg) begin
                    pin_out_reg <= !pin_out_reg;
                end
            end
        end
    end

    // Read data valid in the cycle after the strobe only
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_reg <= 16'h0000;
        end else if (ce) begin
            rdata_reg <= 16'h0000;
            if (rd_stb) begin
                case (addr)
                    `CLKSEL_ADDR_CFG: rdata_reg <= {10'h000, cfg_reg};
                    `CLKSEL_ADDR_DOZE: rdata_reg <= {9'h000, doze_reg};
                    `CLKSEL_ADDR_STAT: begin
                        rdata_reg <= {4'h0, pin_in_reg, pll_en_reg,
                            mode_reg};
                    end
                    default: rdata_reg <= 16'h0000;
                endcase
            end
        end
    end

    assign rdata = rdata_reg;
    assign pll_ref_tick = pll_ref_reg;
    assign pll_en = pll_en_reg;
    assign posc_en = posc_en_reg;
    assign posc_kind = posc_kind_reg;
    assign cpu_clock = cpu_reg;
    assign peripheral_clock = periph_reg;
    assign aux_crystal_pin_out = pin_out_reg;
    assign aux_crystal_pin_oe = pin_oe_reg;
endmodule
`default_nettype wire

// ---- pkg/clksel_defs.svh ----
// Constants of the clock source selector
// Contract
// (R1) Source code 111 runs the fast RC through the divide-by-N stage.
// (R2) Source code 110 runs the fast RC through a fixed divide-by-16.
// (R3) Source code 101 runs the low-power RC directly.
// (R4) Source code 011 with oscillator mode 10 runs the fast crystal via PLL.
// (R5) Source code 011 with oscillator mode 01 runs the medium crystal via PLL.
// (R6) Source code 011 with oscillator mode 00 runs the external clock via PLL.
// (R7) Source code 001 runs the fast RC through divide-by-N then the PLL.
// (R8) Source code 000 runs the undivided fast RC.
// (R9) The erased selection fields decode to the fast RC divide-by-N mode.
// (R10) Peripheral clock equals CPU clock except under doze of 1:2 or slower.
// (R11) In internal and external-clock modes the aux pin follows its cfg bit.
// (R12) Source code 010 runs the primary oscillator without PLL.
`ifndef CLKSEL_DEFS_SVH
`define CLKSEL_DEFS_SVH

`define CLKSEL_ADDR_CFG 4'h0
`define CLKSEL_ADDR_DOZE 4'h1
`define CLKSEL_ADDR_STAT 4'h2

`define CLKSEL_SRC_LSB 0
`define CLKSEL_PMODE_LSB 3
`define CLKSEL_PINCFG_BIT 5
`define CLKSEL_DOZE_EN_BIT 0
`define CLKSEL_DOZE_RATIO_LSB 1
`define CLKSEL_DIVN_LSB 4
`define CLKSEL_STAT_PLL_BIT 10
`define CLKSEL_STAT_PIN_BIT 11

// Erased configuration: every cfg bit reads as one, every doze bit as zero
`define CLKSEL_CFG_RESET 6'h3f
`define CLKSEL_DOZE_RESET 7'h00

`define CLKSEL_SRC_FRC_DIVN 3'h7
`define CLKSEL_SRC_FRC_DIV16 3'h6
`define CLKSEL_SRC_LOW_POWER_RC_MODE 3'h5
`define CLKSEL_SRC_POSC_PLL 3'h3
`define CLKSEL_SRC_POSC 3'h2
`define CLKSEL_SRC_FRC_PLL 3'h1
`define CLKSEL_SRC_FRC 3'h0

`define CLKSEL_PMODE_HS 2'h2
`define CLKSEL_PMODE_XT 2'h1
`define CLKSEL_PMODE_EC 2'h0

`define CLKSEL_DIV16_LOG2 4'h4

`endif

// ---- pkg/clksel_pkg.sv ----
// Types of the clock source selector
`default_nettype none
package clksel_pkg;

    typedef struct packed {
        logic clockout_pin_cfg;
        logic [1:0] primary_osc_mode;
        logic [2:0] new_source_code;
    } clksel_cfg_t;

    typedef struct packed {
        logic [2:0] frc_div_log2;
        logic [2:0] doze_ratio;
        logic doze_en;
    } clksel_doze_t;

    typedef enum logic [9:0] {
        fast_rc_div_n_mode = 10'b00_0000_0001,
        fast_rc_div_sixteen_mode = 10'b00_0000_0010,
        low_power_rc_mode = 10'b00_0000_0100,
        high_speed_crystal_pll_mode = 10'b00_0000_1000,
        medium_crystal_pll_mode = 10'b00_0001_0000,
        ext_clock_pll_mode = 10'b00_0010_0000,
        high_speed_crystal = 10'b00_0100_0000,
        medium_crystal = 10'b00_1000_0000,
        clock_input_mode = 10'b01_0000_0000,
        fast_rc_pll_mode = 10'b10_0000_0000,
        fast_rc_mode = 10'b00_0000_0000
    } clksel_mode_t;

endpackage
`default_nettype wire

// ---- design/clksel_div.sv ----
// Power-of-two tick divider
`default_nettype none
module clksel_div (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic in_tick,
    input wire logic [3:0] div_log2,
    output logic out_tick
);
    logic [15:0] cnt_reg;
    logic [15:0] mask;

    assign mask = (16'h0001 << div_log2) - 16'h0001;
    // Pulse on the last input tick of each group
    assign out_tick = in_tick && ((cnt_reg & mask) == mask);

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_reg <= 16'h0000;
        end else if (ce && in_tick) begin
            cnt_reg <= (cnt_reg & mask) == mask ? 16'h0000
                : cnt_reg + 16'h0001;
        end
    end
endmodule
`default_nettype wire

// ---- bench/clksel_checker.sv ----
// Port-level assertions for the clock source selector
`default_nettype none
module clksel_checker (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [3:0] addr,
    input wire logic rd_stb,
    input wire logic [15:0] rdata,
    input wire logic frc_tick,
    input wire logic low_power_rc_mode_tick,
    input wire logic posc_tick,
    input wire logic pll_out_tick,
    input wire logic pll_en,
    input wire logic posc_en,
    input wire logic [1:0] posc_kind,
    input wire logic cpu_clock,
    input wire logic peripheral_clock,
    input wire logic aux_crystal_pin_oe
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    rdata_idle_a: assert property (ce && $past(ce) && !$past(rd_stb)
        |-> rdata == 16'h0000) else $error("read data outside read slot");
    // Strobes while the clock enable is low are ignored by the block
    stat_onehot_a: assert property ($past(ce && rd_stb && addr == 4'h2)
        |-> $onehot0(rdata[9:0])) else $error("status mode not one-hot");
    stat_pll_a: assert property ($past(ce && rd_stb && addr == 4'h2)
        && $stable(pll_en) |-> rdata[10] == pll_en)
        else $error("status pll bit differs from pll enable");
    unmapped_rd_a: assert property ($past(ce && rd_stb && addr > 4'h2)
        |-> rdata == 16'h0000) else $error("unmapped read not zero");
    cpu_subset_a: assert property (cpu_clock |-> peripheral_clock)
        else $error("cpu tick without peripheral tick");
    // A frozen tick may stand while the clock enable is low
    periph_cause_a: assert property (peripheral_clock && $past(ce)
        |-> $past(frc_tick || low_power_rc_mode_tick || posc_tick || pll_out_tick))
        else $error("peripheral tick without source tick");
    pll_kind_a: assert property (pll_en && posc_en
        |-> posc_kind != 2'h3) else $error("pll on reserved kind");
    crystal_rel_a: assert property (posc_en && posc_kind != 2'h0
        |-> !aux_crystal_pin_oe) else $error("crystal pin driven");

    cover property (peripheral_clock && !cpu_clock);
    cover property (pll_en && posc_en);
    cover property (aux_crystal_pin_oe);
    cover property ($past(rd_stb && addr == 4'h2));
endmodule
`default_nettype wire

// ---- bench/tb.sv ----
// Self-checking bench for the clock source selector
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 0, rst_b = 0, ce = 1, wr_stb = 0, rd_stb = 0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000, rdata;
    logic frc_tick = 0, low_power_rc_mode_tick = 0, posc_tick = 0, pll_out_tick = 0;
    logic pin_in = 0, pll_ref_tick, pll_en, posc_en, cpu_clock;
    logic peripheral_clock, pin_out, pin_oe;
    logic [1:0] posc_kind;
    logic [2:0] cnt = 3'h0;
    int bad_count = 0, n_checks = 0;

    clksel_top dut (.sys_clk(sys_clk), .rst_b(rst_b), .ce(ce),
        .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .rdata(rdata), .frc_tick(frc_tick), .low_power_rc_mode_tick(low_power_rc_mode_tick),
        .posc_tick(posc_tick), .pll_out_tick(pll_out_tick),
        .aux_crystal_pin_in(pin_in), .pll_ref_tick(pll_ref_tick),
        .pll_en(pll_en), .posc_en(posc_en), .posc_kind(posc_kind),
        .cpu_clock(cpu_clock), .peripheral_clock(peripheral_clock),
        .aux_crystal_pin_out(pin_out), .aux_crystal_pin_oe(pin_oe));

    always #20 sys_clk = ~sys_clk;

    // Distinct rates per source: fast RC 1/2, pll 3/4, primary 1/4, lp 1/8
    always @(posedge sys_clk) begin
        cnt <= cnt + 3'h1;
        frc_tick <= cnt[0];
        pll_out_tick <= (cnt[1:0] != 2'h0);
        posc_tick <= (cnt[1:0] == 2'h1);
        low_power_rc_mode_tick <= (cnt == 3'h0);
    end

    task automatic chk(input string nm, input logic [15:0] e, g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge sys_clk);
        wr_stb <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge sys_clk);
        rd_stb <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic t_reset;
        logic [15:0] d;
        rd(4'h0, d);
        chk("cfg reset", 16'h003f, d);
        rd(4'h1, d);
        chk("doze reset", 16'h0000, d);
        rd(4'h2, d);
        chk("status reset", 16'h0001, d);
        // Writes to unmapped and read-only places must not land
        wr(4'h3, 16'hffff);
        wr(4'h2, 16'hfffe);
        rd(4'h3, d);
        chk("unmapped", 16'h0000, d);
        rd(4'h2, d);
        chk("status ro", 16'h0001, d);
    endtask

    function automatic logic [9:0] exp_mode(input logic [2:0] s,
                                            input logic [1:0] p);
        case (s)
            3'h7: return 10'h001;
            3'h6: return 10'h002;
            3'h5: return 10'h004;
            3'h3: return (p == 2'h3) ? 10'h000 : 10'h008 << (2'h2 - p);
            3'h2: return (p == 2'h3) ? 10'h000 : 10'h040 << (2'h2 - p);
            3'h1: return 10'h200;
            default: return 10'h000;
        endcase
    endfunction

    task automatic t_decode;
        logic [15:0] d;
        logic [5:0] c;
        logic [9:0] m;
        logic pll, xtal;
        for (int i = 0; i < 64; i++) begin
            c = i[5:0];
            pin_in <= c[5];
            wr(4'h0, {10'h000, c});
            repeat (3) @(posedge sys_clk);
            rd(4'h2, d);
            m = exp_mode(c[2:0], c[4:3]);
            pll = |(m & 10'h238);
            xtal = |(m & 10'h0d8);
            chk("status", {4'h0, c[5], pll, m}, d);
            chk("outputs", {10'h0, pll, |(m & 10'h1f8), c[4:3],
                !xtal && !c[5], 1'b0}, {10'h0, pll_en, posc_en,
                posc_kind, pin_oe, 1'b0});
        end
    endtask

    // Counts ticks over 128 cycles; reference count skipped when negative
    task automatic meas(input logic [5:0] c, input logic [6:0] dz,
                        input int ep, ec, er);
        int pc, cc, rc, tg, et;
        logic pv;
        wr(4'h0, {10'h000, c});
        wr(4'h1, {9'h000, dz});
        repeat (4) @(posedge sys_clk);
        #1;
        pc = 0;
        cc = 0;
        rc = 0;
        tg = 0;
        pv = pin_out;
        // Crystal modes and a set pin cfg bit keep the pin still
        et = (c[5] || (c[2:1] == 2'h1 && (c[4] ^ c[3]))) ? 0 : ec;
        repeat (128) begin
            @(posedge sys_clk);
            #1;
            pc += peripheral_clock;
            cc += cpu_clock;
            rc += pll_ref_tick;
            tg += (pin_out != pv);
            pv = pin_out;
        end
        chk("pin toggles", et[15:0], tg[15:0]);
        chk("periph ticks", ep[15:0], pc[15:0]);
        chk("cpu ticks", ec[15:0], cc[15:0]);
        if (er >= 0)
            chk("ref ticks", er[15:0], rc[15:0]);
    endtask

    task automatic t_clock;
        meas(6'h20, 7'h00, 64, 64, -1);
        meas(6'h27, 7'h10, 32, 32, -1);
        meas(6'h27, 7'h30, 8, 8, -1);
        meas(6'h26, 7'h00, 4, 4, -1);
        meas(6'h25, 7'h00, 16, 16, -1);
        meas(6'h13, 7'h00, 96, 96, 32);
        meas(6'h0b, 7'h00, 96, 96, 32);
        meas(6'h03, 7'h00, 96, 96, 32);
        meas(6'h01, 7'h10, 96, 96, 32);
        meas(6'h12, 7'h00, 32, 32, -1);
        for (int r = 0; r < 4; r++)
            meas(6'h20, {3'h0, r[2:0], 1'b1}, 64, 64 >> r, -1);
        meas(6'h20, 7'h0e, 64, 64, -1);
    endtask

    // Clock enable low must freeze ticks and ignore strobes
    task automatic t_freeze;
        logic [15:0] d;
        logic pv;
        int moved;
        moved = 0;
        @(posedge sys_clk);
        ce <= 1'b0;
        wr(4'h0, 16'h0025);
        #1 pv = peripheral_clock;
        repeat (16) begin
            @(posedge sys_clk);
            #1;
            moved += (peripheral_clock != pv);
        end
        chk("frozen ticks", 16'h0000, moved[15:0]);
        @(posedge sys_clk);
        ce <= 1'b1;
        rd(4'h0, d);
        chk("cfg kept", 16'h0020, d);
    endtask

    initial begin
        repeat (16) @(posedge sys_clk);
        rst_b <= 1'b1;
        t_reset;
        t_decode;
        t_clock;
        t_freeze;
        test_done;
    end
endmodule

bind clksel_top clksel_checker chk_i (.sys_clk(sys_clk), .rst_b(rst_b),
    .ce(ce), .addr(addr), .rd_stb(rd_stb), .rdata(rdata),
    .frc_tick(frc_tick), .low_power_rc_mode_tick(low_power_rc_mode_tick), .posc_tick(posc_tick),
    .pll_out_tick(pll_out_tick), .pll_en(pll_en), .posc_en(posc_en),
    .posc_kind(posc_kind), .cpu_clock(cpu_clock),
    .peripheral_clock(peripheral_clock),
    .aux_crystal_pin_oe(aux_crystal_pin_oe));
`default_nettype wire
